// ===== rtl/pfds_debounce.sv
// one port's sampler and integrator debounce filter
// assumes tick_i is a one-cycle strobe at the sampling rate
module pfds_debounce (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic tick_i,
  input wire logic raw_i,
  input wire logic enable_i,
  input wire logic [15:0] step_i,
  output logic level_o
);
  import pfds_pkg::*;

  logic [15:0] integ_q;
  logic [15:0] integ_d;
  logic level_q;

  always_comb begin
    if (!enable_i) begin
      integ_d = raw_i ? PFDS_INTEG_MAX : 16'h0000;
    end else if (raw_i) begin
      integ_d = (integ_q > PFDS_INTEG_MAX - step_i) ? PFDS_INTEG_MAX : integ_q + step_i;
    end else begin
      integ_d = (integ_q < step_i) ? 16'h0000 : integ_q - step_i;
    end
  end

  // a reversion simply ramps back, so it costs twice its own length
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      integ_q <= 16'h0000;
    end else if (tick_i) begin
      integ_q <= integ_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      level_q <= 1'b0;
    end else if (tick_i) begin
      if (!enable_i) begin
        level_q <= raw_i;
      end else if (!level_q && integ_d == PFDS_INTEG_MAX) begin
        level_q <= 1'b1;
      end else if (level_q && integ_d == 16'h0000) begin
        level_q <= 1'b0;
      end
    end
  end

  assign level_o = level_q;
endmodule

// ===== rtl/pfds_pkg.sv
// constants and carrier types for the pulse, frequency and duty sampler
// assumes a single 20 MHz core clock and synchronous, active-high reset
package pfds_pkg;
  localparam int unsigned PFDS_NPORT = 16;
  localparam int unsigned PFDS_CLK_HZ = 20_000_000;
  localparam int unsigned PFDS_SAMPLE_HZ = 4096;
  // one sampling interval, about 244 us; the divider rounds down
  localparam int unsigned PFDS_TICK_CYCLES = PFDS_CLK_HZ / PFDS_SAMPLE_HZ;
  localparam int unsigned PFDS_TICK_W = 13;
  // longest interval between requests is 15.9375 s of ticks, which fits 16 bits
  localparam int unsigned PFDS_MAX_INTERVAL_TICKS = 65280;
  localparam int unsigned PFDS_ACC_W = 16;
  // debounce time is (n + 1) sampling intervals; n = 12 gives about 3.17 ms
  localparam logic [7:0] PFDS_DEB_DEFAULT = 8'h0c;
  localparam logic [15:0] PFDS_INTEG_MAX = 16'hffff;
  localparam logic [15:0] PFDS_DEB_DEFAULT_STEP = 16'((32'h0000ffff + 32'h0000000c) / 32'h0000000d);
  // command codes: 23 per measurement kind, starting at 1
  localparam logic [7:0] PFDS_CODE_FIRST = 8'h01;
  localparam logic [7:0] PFDS_CODE_LAST = 8'h45;
  localparam logic [7:0] PFDS_CODES_PER_KIND = 8'h17;
  localparam logic [7:0] PFDS_OFF_GROUP4 = 8'h10;
  localparam logic [7:0] PFDS_OFF_GROUP8 = 8'h14;
  localparam logic [7:0] PFDS_OFF_ALL = 8'h16;

  typedef enum logic [1:0] {
    PFDS_MEAS_COUNT,
    PFDS_MEAS_FREQ,
    PFDS_MEAS_DUTY
  } pfds_meas_type;

  typedef struct packed {
    logic [3:0] port;
    logic [7:0] param;
  } pfds_cfg_type;

  typedef struct packed {
    pfds_meas_type meas;
    logic [3:0] port;
    logic [15:0] value_a;
    logic [15:0] value_b;
  } pfds_resp_type;
endpackage

// ===== rtl/pfds_sampler.sv
// sixteen-port pulse count, frequency and duty measurement engine
// assumes port_i is synchronous to core_clk_i and the host waits while busy_o
module pfds_sampler #(
  parameter int unsigned TICK_DIV = pfds_pkg::PFDS_TICK_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] port_i,
  input wire logic cfg_wr_i,
  input wire pfds_pkg::pfds_cfg_type cfg_i,
  input wire logic req_valid_i,
  input wire logic [7:0] req_code_i,
  output logic busy_o,
  output logic resp_valid_o,
  output pfds_pkg::pfds_resp_type resp_o,
  output logic req_err_o,
  output logic [15:0] level_o
);
  import pfds_pkg::*;

  typedef enum logic {
    PFDS_ST_IDLE,
    PFDS_ST_SEND
  } pfds_state_type;

  logic [PFDS_TICK_W-1:0] div_q;
  logic tick_q;
  logic tick_d1_q;
  logic [PFDS_ACC_W-1:0] ts_q;
  logic [7:0] param_q [PFDS_NPORT];
  logic [15:0] step_q [PFDS_NPORT];
  logic [15:0] lvl;
  logic [15:0] prev_q;
  logic [15:0] cnt_q [PFDS_NPORT];
  logic [15:0] fcyc_q [PFDS_NPORT];
  logic [15:0] first_q [PFDS_NPORT];
  logic [15:0] last_q [PFDS_NPORT];
  logic [15:0] started_q;
  logic [15:0] chigh_q [PFDS_NPORT];
  logic [15:0] cper_q [PFDS_NPORT];
  logic [15:0] hacc_q [PFDS_NPORT];
  logic [15:0] pacc_q [PFDS_NPORT];
  pfds_state_type state_q;
  pfds_meas_type meas_q;
  logic [3:0] idx_q;
  logic [3:0] end_q;
  logic busy_q;
  logic resp_valid_q;
  pfds_resp_type resp_q;
  logic err_q;
  logic [15:0] clr_cnt;
  logic [15:0] clr_frq;
  logic [15:0] clr_dty;
  logic [7:0] code_off;
  logic [7:0] code_kind;
  logic [7:0] code_rem;
  logic code_ok;
  logic [3:0] sel_first;
  logic [3:0] sel_last;

  // sampling tick: divider of the core clock down to 4096 Hz
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == PFDS_TICK_W'(TICK_DIV - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // the filters update on tick_q, the edge logic one cycle later
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tick_d1_q <= 1'b0;
    end else begin
      tick_d1_q <= tick_q;
    end
  end

  // free-running time base in sampling intervals; wraps after 16 s
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ts_q <= '0;
    end else if (tick_d1_q) begin
      ts_q <= ts_q + 1'b1;
    end
  end

  // debounce parameter and the matching integrator step per port
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < PFDS_NPORT; i++) begin
        param_q[i] <= PFDS_DEB_DEFAULT;
        step_q[i] <= PFDS_DEB_DEFAULT_STEP;
      end
    end else if (cfg_wr_i) begin
      param_q[cfg_i.port] <= cfg_i.param;
      // ceil(max / (n + 1)) reaches the far limit in n + 1 ticks
      step_q[cfg_i.port] <= 16'((17'(PFDS_INTEG_MAX) + 17'(cfg_i.param))
                               / (17'(cfg_i.param) + 17'h00001));
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      prev_q <= '0;
    end else if (tick_d1_q) begin
      prev_q <= lvl;
    end
  end

  // command decode: 23 codes per measurement kind
  always_comb begin
    code_off = req_code_i - PFDS_CODE_FIRST;
    code_kind = code_off / PFDS_CODES_PER_KIND;
    code_rem = code_off % PFDS_CODES_PER_KIND;
    code_ok = (req_code_i >= PFDS_CODE_FIRST) && (req_code_i <= PFDS_CODE_LAST);
    if (code_rem < PFDS_OFF_GROUP4) begin
      sel_first = code_rem[3:0];
      sel_last = code_rem[3:0];
    end else if (code_rem < PFDS_OFF_GROUP8) begin
      sel_first = {code_rem[1:0], 2'b00};
      sel_last = {code_rem[1:0], 2'b11};
    end else if (code_rem < PFDS_OFF_ALL) begin
      sel_first = {code_rem[0], 3'b000};
      sel_last = {code_rem[0], 3'b111};
    end else begin
      sel_first = 4'h0;
      sel_last = 4'hf;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_q <= PFDS_ST_IDLE;
      meas_q <= PFDS_MEAS_COUNT;
      idx_q <= 4'h0;
      end_q <= 4'h0;
    end else begin
      case (state_q)
        PFDS_ST_IDLE: begin
          if (req_valid_i && code_ok) begin
            state_q <= PFDS_ST_SEND;
            meas_q <= pfds_meas_type'(code_kind[1:0]);
            idx_q <= sel_first;
            end_q <= sel_last;
          end
        end
        PFDS_ST_SEND: begin
          if (idx_q == end_q) begin
            state_q <= PFDS_ST_IDLE;
          end else begin
            idx_q <= idx_q + 1'b1;
          end
        end
        default: begin
          state_q <= PFDS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      busy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      busy_q <= (state_q == PFDS_ST_IDLE) ? (req_valid_i && code_ok) : (idx_q != end_q);
      err_q <= (state_q == PFDS_ST_IDLE) && req_valid_i && !code_ok;
    end
  end

  // answer word reads the values before this cycle's clear lands
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      resp_valid_q <= 1'b0;
      resp_q <= '0;
    end else begin
      resp_valid_q <= (state_q == PFDS_ST_SEND);
      if (state_q == PFDS_ST_SEND) begin
        resp_q.meas <= meas_q;
        resp_q.port <= idx_q;
        case (meas_q)
          PFDS_MEAS_COUNT: begin
            resp_q.value_a <= cnt_q[idx_q];
            resp_q.value_b <= 16'h0000;
          end
          PFDS_MEAS_FREQ: begin
            resp_q.value_a <= fcyc_q[idx_q];
            resp_q.value_b <= (fcyc_q[idx_q] == 16'h0000) ? 16'h0000
                              : last_q[idx_q] - first_q[idx_q];
          end
          default: begin
            resp_q.value_a <= hacc_q[idx_q];
            resp_q.value_b <= pacc_q[idx_q];
          end
        endcase
      end
    end
  end

  generate
    for (genvar p = 0; p < PFDS_NPORT; p++) begin : g_port
      logic rise;

      pfds_debounce u_deb (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .tick_i(tick_q),
        .raw_i(port_i[p]),
        .enable_i(param_q[p] != 8'h00),
        .step_i(step_q[p]),
        .level_o(lvl[p])
      );

      // edges are only ever seen at sample spacing, hence the 244 us floor
      assign rise = tick_d1_q && lvl[p] && !prev_q[p];
      assign clr_cnt[p] = (state_q == PFDS_ST_SEND) && (meas_q == PFDS_MEAS_COUNT)
                          && (idx_q == 4'(p));
      assign clr_frq[p] = (state_q == PFDS_ST_SEND) && (meas_q == PFDS_MEAS_FREQ)
                          && (idx_q == 4'(p));
      assign clr_dty[p] = (state_q == PFDS_ST_SEND) && (meas_q == PFDS_MEAS_DUTY)
                          && (idx_q == 4'(p));

      // pulse count; an edge in the clearing cycle is kept
      always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
          cnt_q[p] <= '0;
        end else begin
          cnt_q[p] <= (clr_cnt[p] ? 16'h0000 : cnt_q[p]) + {15'h0000, rise};
        end
      end

      // frequency: whole cycles between rising edges; a clear restarts the
      // interval at the last counted edge so no cycle is lost
      always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
          started_q[p] <= 1'b0;
          fcyc_q[p] <= '0;
          first_q[p] <= '0;
          last_q[p] <= '0;
        end else begin
          if (rise && !started_q[p]) begin
            started_q[p] <= 1'b1;
            first_q[p] <= ts_q;
            last_q[p] <= ts_q;
            fcyc_q[p] <= 16'h0000;
          end else if (rise) begin
            fcyc_q[p] <= (clr_frq[p] ? 16'h0000 : fcyc_q[p]) + 16'h0001;
            last_q[p] <= ts_q;
            if (clr_frq[p]) begin
              first_q[p] <= last_q[p];
            end
          end else if (clr_frq[p]) begin
            fcyc_q[p] <= 16'h0000;
            first_q[p] <= last_q[p];
          end
        end
      end

      // duty: the running cycle accumulates per tick and is committed on
      // the next rising edge, so only whole cycles enter the totals
      always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
          chigh_q[p] <= '0;
          cper_q[p] <= '0;
        end else if (rise) begin
          chigh_q[p] <= 16'h0001;
          cper_q[p] <= 16'h0001;
        end else if (tick_d1_q && started_q[p]) begin
          chigh_q[p] <= chigh_q[p] + {15'h0000, lvl[p]};
          cper_q[p] <= cper_q[p] + 16'h0001;
        end
      end

      always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
          hacc_q[p] <= '0;
          pacc_q[p] <= '0;
        end else if (rise && started_q[p]) begin
          hacc_q[p] <= (clr_dty[p] ? 16'h0000 : hacc_q[p]) + chigh_q[p];
          pacc_q[p] <= (clr_dty[p] ? 16'h0000 : pacc_q[p]) + cper_q[p];
        end else if (clr_dty[p]) begin
          hacc_q[p] <= 16'h0000;
          pacc_q[p] <= 16'h0000;
        end
      end
    end
  endgenerate

  assign busy_o = busy_q;
  assign resp_valid_o = resp_valid_q;
  assign resp_o = resp_q;
  assign req_err_o = err_q;
  assign level_o = lvl;
endmodule

// ===== tb/pfds_host_model.sv
// host model: issues one command and waits for all its words
// assumes one caller at a time and inputs driven on the falling edge
module pfds_host_model (
  input wire logic clk_i,
  input wire logic resp_valid_i,
  output logic req_valid_o,
  output logic [7:0] req_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_valid_o = 1'b0;
    req_code_o = 8'h5a;
  end
  // a released code bus shows the inverse value, never a stale copy
  task automatic issue(input logic [7:0] code, input int words, input int gap = 0);
    int seen;
    repeat (gap + 1) @(negedge clk_i);
    req_valid_o = 1'b1;
    req_code_o = code;
    @(negedge clk_i);
    req_valid_o = 1'b0;
    req_code_o = ~code;
    seen = 0;
    for (int t = 0; t < 40 && seen < words; t++) begin
      @(posedge clk_i);
      if (resp_valid_i === 1'b1) seen++;
    end
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// ===== tb/pfds_sampler_sva.sv
// port checker for the sampler, bound to every instance
// assumes one clock and a synchronous, active-high reset
module pfds_sampler_sva (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] port_i,
  input wire logic cfg_wr_i,
  input wire pfds_pkg::pfds_cfg_type cfg_i,
  input wire logic req_valid_i,
  input wire logic [7:0] req_code_i,
  input wire logic busy_o,
  input wire logic resp_valid_o,
  input wire pfds_pkg::pfds_resp_type resp_o,
  input wire logic req_err_o,
  input wire logic [15:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import pfds_pkg::*;
  logic [4:0] busy_run_q;
  // busy may never outlast the longest answer of sixteen words
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !busy_o) begin
      busy_run_q <= 5'h00;
    end else begin
      busy_run_q <= busy_run_q + 5'h01;
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_idle_req;
    req_valid_i && !busy_o && !resp_valid_o;
  endsequence
  sequence s_good_req;
    s_idle_req ##0 (req_code_i != 8'h00 && req_code_i <= 8'h45);
  endsequence
  sequence s_bad_req;
    s_idle_req ##0 (req_code_i == 8'h00 || req_code_i > 8'h45);
  endsequence
  chk_take_answer: assert property (s_good_req |=> busy_o ##1 resp_valid_o)
    else $error("accepted request not answered");
  chk_err_flag: assert property (s_bad_req |=> req_err_o && !busy_o)
    else $error("bad code not flagged");
  chk_err_cause: assert property (req_err_o |-> $past(req_valid_i) &&
    ($past(req_code_i) == 8'h00 || $past(req_code_i) > 8'h45))
    else $error("error flag without bad code");
  chk_busy_word: assert property (busy_o |=> resp_valid_o)
    else $error("busy cycle without word");
  chk_word_cause: assert property (resp_valid_o |-> $past(busy_o))
    else $error("word without busy");
  chk_busy_len: assert property (busy_run_q <= 5'h10)
    else $error("busy too long");
  chk_resp_hold: assert property (!resp_valid_o |-> $stable(resp_o))
    else $error("answer changed between words");
  chk_count_b: assert property (resp_valid_o && resp_o.meas == PFDS_MEAS_COUNT
    |-> resp_o.value_b == 16'h0000)
    else $error("count word with nonzero second value");
  chk_freq_span: assert property (resp_valid_o && resp_o.meas == PFDS_MEAS_FREQ
    |-> {1'b0, resp_o.value_b} >= {resp_o.value_a, 1'b0})
    else $error("cycle span shorter than two ticks a cycle");
  chk_duty_frac: assert property (resp_valid_o && resp_o.meas == PFDS_MEAS_DUTY
    |-> resp_o.value_a <= resp_o.value_b)
    else $error("high time above period");
  chk_level_rise: assert property (((level_o & ~$past(level_o))
    & ~($past(port_i) | $past(port_i, 2))) == 16'h0000)
    else $error("level rose without high input");
endmodule
bind pfds_sampler pfds_sampler_sva u_pfds_sampler_sva (.core_clk_i, .sys_rst_i, .port_i,
  .cfg_wr_i, .cfg_i, .req_valid_i, .req_code_i, .busy_o, .resp_valid_o, .resp_o,
  .req_err_o, .level_o);

// ===== tb/pfds_sampler_test.sv
// self-checking bench for the sampler, host model on the request side
// assumes package, design, checker and host model compiled first
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch at %0t line %0d", $time, `__LINE__); end end
module pfds_sampler_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pfds_pkg::*;
  localparam int TD = 16;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [15:0] port_q = 16'h0000;
  logic cfg_wr_q = 1'b0;
  pfds_cfg_type cfg_q = '0;
  logic req_valid, busy, resp_valid, req_err;
  logic [7:0] req_code;
  pfds_resp_type resp;
  logic [15:0] level;
  pfds_resp_type words[$];
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int errs = 0;
  pfds_sampler #(.TICK_DIV(TD)) u_pfds_sampler (.core_clk_i, .sys_rst_i, .port_i(port_q),
    .cfg_wr_i(cfg_wr_q), .cfg_i(cfg_q), .req_valid_i(req_valid), .req_code_i(req_code),
    .busy_o(busy), .resp_valid_o(resp_valid), .resp_o(resp), .req_err_o(req_err),
    .level_o(level));
  pfds_host_model u_host (.clk_i(core_clk_i), .resp_valid_i(resp_valid),
    .req_valid_o(req_valid), .req_code_o(req_code));
  initial forever #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles++;
    if (resp_valid === 1'b1) words.push_back(resp);
    if (req_err === 1'b1) errs++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  function automatic pfds_resp_type rw(pfds_meas_type m, int p, int a, int b);
    return '{m, 4'(p), 16'(a), 16'(b)};
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cfg(input int p, input int n);
    @(negedge core_clk_i);
    cfg_wr_q = 1'b1;
    cfg_q = '{port: 4'(p), param: 8'(n)};
    @(negedge core_clk_i);
    cfg_wr_q = 1'b0;
  endtask
  task automatic rd(input int code, input int n, input int gap = 0);
    words.delete();
    u_host.issue(8'(code), n, gap);
  endtask
  task automatic t_count();
    cfg(0, 0);
    rd(1, 1);
    @(negedge core_clk_i);
    // pulses just over one interval, high and low, must all be caught
    repeat (3) begin
      port_q[0] = 1'b1;
      repeat (TD + 1) @(negedge core_clk_i);
      port_q[0] = 1'b0;
      repeat (TD + 1) @(negedge core_clk_i);
    end
    rd(1, 1);
    `CHK(words[0], rw(PFDS_MEAS_COUNT, 0, 3, 0))
    rd(1, 1, 5);
    `CHK(words[0], rw(PFDS_MEAS_COUNT, 0, 0, 0))
    $display("t_count done");
  endtask
  // reads sit two ticks after a rise so no edge races a clear
  task automatic t_freq();
    cfg(1, 0);
    words.delete();
    fork
      repeat (7) begin
        port_q[1] = 1'b1;
        repeat (2 * TD) @(negedge core_clk_i);
        port_q[1] = 1'b0;
        repeat (2 * TD) @(negedge core_clk_i);
      end
      begin
        repeat (10 * TD - 1) @(negedge core_clk_i);
        u_host.issue(8'd25, 1);
        u_host.issue(8'd48, 1);
      end
      begin
        repeat (26 * TD - 1) @(negedge core_clk_i);
        u_host.issue(8'd25, 1);
        u_host.issue(8'd48, 1);
      end
    join
    `CHK(words[0], rw(PFDS_MEAS_FREQ, 1, 2, 8))
    `CHK(words[1], rw(PFDS_MEAS_DUTY, 1, 4, 8))
    `CHK(words[2], rw(PFDS_MEAS_FREQ, 1, 4, 16))
    `CHK(words[3], rw(PFDS_MEAS_DUTY, 1, 8, 16))
    $display("t_freq done");
  endtask
  task automatic t_deb(input int p, input int n, input bit bnc);
    int cnt;
    int k;
    k = n + 1 + (bnc ? 2 : 0);
    if (n != 12) cfg(p, n);
    @(negedge core_clk_i);
    port_q[p] = 1'b1;
    cnt = 0;
    if (bnc) begin
      repeat (2 * TD) @(negedge core_clk_i);
      port_q[p] = 1'b0;
      repeat (TD) @(negedge core_clk_i);
      port_q[p] = 1'b1;
      cnt = 3 * TD;
    end
    while (level[p] !== 1'b1 && cnt < 400) begin
      @(negedge core_clk_i);
      cnt++;
    end
    `CHK(cnt > (k - 1) * TD && cnt <= k * TD + 2, 1'b1)
    port_q[p] = 1'b0;
    $display("t_deb port %0d done", p);
  endtask
  task automatic t_cmds();
    int kind, off, nw, base;
    errs = 0;
    rd(0, 0);
    rd(70, 0);
    rd(255, 0, 3);
    `CHK(errs, 3)
    for (int c = 1; c <= 69; c++) begin
      kind = (c - 1) / 23;
      off = (c - 1) % 23;
      nw = off < 16 ? 1 : off < 20 ? 4 : off < 22 ? 8 : 16;
      base = off < 16 ? off : off < 20 ? (off - 16) * 4 : off < 22 ? (off - 20) * 8 : 0;
      rd(c, nw, c % 3);
      `CHK(words.size(), nw)
      foreach (words[i]) `CHK({words[i].meas, words[i].port}, {2'(kind), 4'(base + i)})
    end
    $display("t_cmds done");
  endtask
  initial begin
    repeat (6) @(posedge core_clk_i);
    @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    t_count();
    t_freq();
    t_deb(2, 12, 1'b0);
    t_deb(3, 0, 1'b0);
    t_deb(4, 1, 1'b0);
    t_deb(5, 5, 1'b0);
    t_deb(6, 3, 1'b1);
    t_cmds();
    conclude();
  end
endmodule
